// File: branch_shift_execute.sv
/*
  Executes unconditional branches, breaks and barrel shifts of a 32-bit core,
  tracking PC, latency, delay slot, the break flag and the immediate prefix.
  Assumes register-file operands are valid with issue_valid and that the
  surrounding pipeline holds issue while busy is high.
*/
`timescale 1ns/1ps
module branch_shift_execute #(
  parameter bit USE_BARREL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Issue
  input wire logic issue_valid,
  input wire logic [bse_pkg::XLEN-1:0] instr,
  input wire logic [bse_pkg::XLEN-1:0] first_source_register,
  input wire logic [bse_pkg::XLEN-1:0] second_source_register,
  // Status
  input wire logic break_clear,
  output logic break_in_progress_flag,
  output logic busy,
  output logic illegal,
  // Program counter
  output logic [bse_pkg::XLEN-1:0] pc,
  output logic pc_load,
  output logic slot_allow,
  // Destination write
  output logic wr_en,
  output logic [bse_pkg::RIDX_W-1:0] wr_idx,
  output logic [bse_pkg::XLEN-1:0] wr_data
);
  import bse_pkg::*;

  typedef enum {ST_IDLE, ST_WAIT} state_t;

  function automatic logic [XLEN-1:0] ext_imm(input logic [IMM_W-1:0] imm,
                                               input logic pfx_v,
                                               input logic [IMM_W-1:0] pfx_hi);
    ext_imm = pfx_v ? {pfx_hi, imm} : {{(XLEN-IMM_W){imm[IMM_W-1]}}, imm};
  endfunction

  logic rst_s1_ff;
  logic rst_s2_ff;
  wire logic rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_n = rst_s2_ff;

  // Field decode
  wire logic [5:0] opc;
  wire logic [RIDX_W-1:0] rd_f;
  wire logic [RIDX_W-1:0] ra_f;
  wire logic [IMM_W-1:0] imm_f;
  assign opc = instr[31:26];
  assign rd_f = instr[25:21];
  assign ra_f = instr[20:16];
  assign imm_f = instr[15:0];

  logic pfx_v_ff;
  logic [IMM_W-1:0] pfx_hi_ff;
  state_t state_ff;
  logic [1:0] cnt_ff;
  logic [XLEN-1:0] pc_ff;
  logic bip_ff;
  logic [XLEN-1:0] wr_data_ff;
  logic [RIDX_W-1:0] wr_idx_ff;
  logic wr_en_ff;
  logic pc_load_ff;
  logic slot_ff;
  logic illegal_ff;

  wire logic accept;
  assign accept = issue_valid && state_ff == ST_IDLE;

  wire logic is_br_reg;
  wire logic is_br_imm;
  wire logic is_brk;
  wire logic is_bs_reg;
  wire logic is_bs_imm;
  wire logic is_pfx;
  wire logic f_d;
  wire logic f_a;
  wire logic f_l;
  assign is_pfx = accept && opc == OPC_IMM_PFX;
  assign is_brk = (opc == OPC_BR_REG || opc == OPC_BR_IMM) && ra_f == BRK_SEL;
  assign f_d = instr[POS_D];
  assign f_a = instr[POS_A];
  assign f_l = instr[POS_L];
  // Link without delay has no encoding
  wire logic bad_link;
  assign bad_link = f_l && !f_d && !is_brk;
  assign is_br_reg = accept && opc == OPC_BR_REG && !is_brk && !bad_link;
  assign is_br_imm = accept && opc == OPC_BR_IMM && !is_brk && !bad_link;
  assign is_bs_reg = accept && opc == OPC_BS_REG && USE_BARREL;
  assign is_bs_imm = accept && opc == OPC_BS_IMM && USE_BARREL;
  wire logic is_brk_r;
  wire logic is_brk_i;
  assign is_brk_r = accept && opc == OPC_BR_REG && is_brk;
  assign is_brk_i = accept && opc == OPC_BR_IMM && is_brk;
  wire logic is_bad;
  assign is_bad = accept && !is_pfx && !is_br_reg && !is_br_imm && !is_brk_r && !is_brk_i
                  && !is_bs_reg && !is_bs_imm;

  // Immediate operand: prefix applies only to immediate branch forms
  wire logic [XLEN-1:0] imm32;
  assign imm32 = ext_imm(imm_f, pfx_v_ff, pfx_hi_ff);

  wire logic [XLEN-1:0] br_off;
  assign br_off = (opc == OPC_BR_IMM) ? imm32 : second_source_register;
  wire logic [XLEN-1:0] br_tgt;
  assign br_tgt = f_a ? br_off : pc_ff + br_off;

  // Shifter operands
  wire logic [SHAMT_W-1:0] sh_amt;
  assign sh_amt = is_bs_imm ? imm_f[SHAMT_W-1:0]
                            : second_source_register[SHAMT_W-1:0];
  wire logic sh_left;
  wire logic sh_arith;
  assign sh_left = instr[POS_S];
  assign sh_arith = instr[POS_T] && !instr[POS_S];
  wire logic [XLEN-1:0] sh_res;
  bse_shifter u_shifter (
    .src(first_source_register),
    .amount(sh_amt),
    .left(sh_left),
    .arith(sh_arith),
    .result(sh_res)
  );

  // Next-state values
  wire logic any_br;
  assign any_br = is_br_reg || is_br_imm;
  wire logic any_brk;
  assign any_brk = is_brk_r || is_brk_i;
  wire logic [1:0] nxt_cnt;
  assign nxt_cnt = any_brk ? LAT_BRK :
                   any_br ? (f_d ? LAT_BR_DLY : LAT_BR_NODLY) :
                   LAT_BS;
  wire logic start;
  assign start = any_br || any_brk || is_bs_reg || is_bs_imm;
  wire logic [XLEN-1:0] nxt_pc;
  assign nxt_pc = any_br ? br_tgt :
                  is_brk_r ? second_source_register :
                  is_brk_i ? imm32 :
                  pc_ff;
  wire logic nxt_wr_en;
  assign nxt_wr_en = (any_br && f_l) || any_brk || is_bs_reg || is_bs_imm;
  wire logic [XLEN-1:0] nxt_wr_data;
  assign nxt_wr_data = (is_bs_reg || is_bs_imm) ? sh_res : pc_ff;
  wire logic nxt_bip;
  assign nxt_bip = any_brk ? 1'b1 : (break_clear ? 1'b0 : bip_ff);
  wire logic last;
  assign last = state_ff == ST_WAIT && cnt_ff == 2'h1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pfx_v_ff <= 1'b0;
      pfx_hi_ff <= '0;
    end else if (accept) begin
      pfx_v_ff <= is_pfx;
      pfx_hi_ff <= imm_f;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 2'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            state_ff <= ST_WAIT;
            cnt_ff <= nxt_cnt - 2'h1;
          end
        end
        default: begin
          if (last) begin
            state_ff <= ST_IDLE;
          end
          cnt_ff <= cnt_ff - 2'h1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff <= PC_RESET;
      bip_ff <= 1'b0;
      wr_data_ff <= '0;
      wr_idx_ff <= '0;
      wr_en_ff <= 1'b0;
      pc_load_ff <= 1'b0;
      slot_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      bip_ff <= nxt_bip;
      illegal_ff <= is_bad;
      if (start) begin
        pc_ff <= nxt_pc;
        wr_data_ff <= nxt_wr_data;
        wr_idx_ff <= rd_f;
        wr_en_ff <= nxt_wr_en;
        pc_load_ff <= any_br || any_brk;
        slot_ff <= any_br && f_d;
      end else if (last) begin
        wr_en_ff <= 1'b0;
        pc_load_ff <= 1'b0;
        slot_ff <= 1'b0;
      end
    end
  end

  assign busy = state_ff == ST_WAIT;
  assign pc = pc_ff;
  assign break_in_progress_flag = bip_ff;
  assign illegal = illegal_ff;
  // Results are committed on the last cycle of the latency
  assign wr_en = wr_en_ff && last;
  assign wr_idx = wr_idx_ff;
  assign wr_data = wr_data_ff;
  assign pc_load = pc_load_ff && last;
  assign slot_allow = slot_ff && last;

  // Checks
  sequence s_br_issue;
    (is_br_reg || is_br_imm) && f_d;
  endsequence
  sequence s_br_nodly;
    (is_br_reg || is_br_imm) && !f_d;
  endsequence
  sequence s_any_brk_issue;
    is_brk_r || is_brk_i;
  endsequence
  sequence s_any_shift_issue;
    is_bs_reg || is_bs_imm;
  endsequence
  // Commit in the first cycle after issue, idle in the next
  sequence s_commit_two;
    (busy && last) ##1 !busy;
  endsequence
  // One wait cycle, commit in the second, idle in the third
  sequence s_commit_three;
    (busy && !last) ##1 (busy && last) ##1 !busy;
  endsequence

  // Latency and commit timing
  chk_dly_latency: assert property (@(posedge clk) disable iff (!rst_n)
    s_br_issue |=> (pc_load && slot_allow) ##0 s_commit_two)
    else $error("delayed branch latency wrong");
  chk_nodly_latency: assert property (@(posedge clk) disable iff (!rst_n)
    s_br_nodly |=> !pc_load ##1 pc_load && !slot_allow)
    else $error("undelayed branch latency wrong");
  chk_rel_target: assert property (@(posedge clk) disable iff (!rst_n)
    is_br_reg && !f_a |=> pc == $past(pc) + $past(second_source_register))
    else $error("relative register target wrong");
  chk_abs_target: assert property (@(posedge clk) disable iff (!rst_n)
    is_br_imm && f_a |=> pc == $past(imm32))
    else $error("absolute immediate target wrong");
  chk_link_pc: assert property (@(posedge clk) disable iff (!rst_n)
    is_br_reg && f_l |=> wr_data == $past(pc) && wr_en)
    else $error("link value wrong");
  chk_brk_flag: assert property (@(posedge clk) disable iff (!rst_n)
    is_brk_r |=> break_in_progress_flag && pc == $past(second_source_register) ##1 pc_load)
    else $error("break did not jump or flag");
  chk_brki_sext: assert property (@(posedge clk) disable iff (!rst_n)
    is_brk_i && !pfx_v_ff |=> pc[XLEN-1:IMM_W] == {(XLEN-IMM_W){$past(imm_f[IMM_W-1])}})
    else $error("break immediate not sign-extended");
  chk_shift_time: assert property (@(posedge clk) disable iff (!rst_n)
    s_any_shift_issue |=> (wr_en && !pc_load) ##0 s_commit_two)
    else $error("shift latency wrong");
  chk_no_link_nodly: assert property (@(posedge clk) disable iff (!rst_n)
    accept && opc == OPC_BR_REG && bad_link |=> illegal && !busy)
    else $error("link without delay accepted");
  chk_nodly_busy: assert property (@(posedge clk) disable iff (!rst_n)
    s_br_nodly |=> s_commit_three)
    else $error("undelayed branch busy window wrong");
  chk_brk_time: assert property (@(posedge clk) disable iff (!rst_n)
    s_any_brk_issue |=> !pc_load ##1 (pc_load && wr_en && !slot_allow) ##1 !busy)
    else $error("break latency wrong");
  chk_load_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    pc_load |=> !pc_load)
    else $error("load pulse longer than one cycle");
  chk_slot_load: assert property (@(posedge clk) disable iff (!rst_n)
    slot_allow |-> pc_load)
    else $error("slot allowed without a jump");

  // Break flag and immediate prefix
  chk_bip_set: assert property (@(posedge clk) disable iff (!rst_n)
    s_any_brk_issue |=> break_in_progress_flag)
    else $error("break did not set the flag");
  chk_bip_clear: assert property (@(posedge clk) disable iff (!rst_n)
    break_clear && !any_brk |=> !break_in_progress_flag)
    else $error("break flag not cleared");
  chk_pfx_upper: assert property (@(posedge clk) disable iff (!rst_n)
    is_brk_i && pfx_v_ff |=> pc == {$past(pfx_hi_ff), $past(imm_f)})
    else $error("prefix upper half not used");
  chk_brki_link: assert property (@(posedge clk) disable iff (!rst_n)
    is_brk_i |=> wr_data == $past(pc))
    else $error("break immediate link value wrong");

  // Shift operands and fill
  chk_left_shift: assert property (@(posedge clk) disable iff (!rst_n)
    is_bs_reg && instr[POS_S]
      |=> wr_data == $past(first_source_register << second_source_register[SHAMT_W-1:0]))
    else $error("register left shift wrong");
  chk_imm_amount: assert property (@(posedge clk) disable iff (!rst_n)
    is_bs_imm && !instr[POS_S] && !instr[POS_T]
      |=> wr_data == $past(first_source_register >> instr[SHAMT_W-1:0]))
    else $error("immediate shift amount wrong");
  chk_arith_sign: assert property (@(posedge clk) disable iff (!rst_n)
    is_bs_reg && instr[POS_T] && !instr[POS_S]
      |=> wr_data[XLEN-1] == $past(first_source_register[XLEN-1]))
    else $error("arithmetic shift lost the sign");
endmodule

// File: bse_pkg.sv
/*
  Constants, opcode encodings and latencies for the branch, break and barrel-shift executor.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bse_pkg;
  localparam int unsigned XLEN = 32;
  localparam int unsigned RIDX_W = 5;
  localparam int unsigned IMM_W = 16;
  localparam int unsigned SHAMT_W = 5;
  // Major opcode, instruction bits 0..5 (big-endian numbering, word bits 31..26)
  localparam logic [5:0] OPC_BR_REG = 6'h26;
  localparam logic [5:0] OPC_BR_IMM = 6'h2E;
  localparam logic [5:0] OPC_BS_REG = 6'h11;
  localparam logic [5:0] OPC_BS_IMM = 6'h19;
  localparam logic [5:0] OPC_IMM_PFX = 6'h2C;
  // Flag positions in the rA field (word bits 20..16): D A L
  localparam int unsigned POS_D = 20;
  localparam int unsigned POS_A = 19;
  localparam int unsigned POS_L = 18;
  // Break selector: rA field value 0x0C (D=0, A=1, L=1, low bits 00)
  localparam logic [4:0] BRK_SEL = 5'h0C;
  // Shift flags in the low half (word bits 10 and 9): S T
  localparam int unsigned POS_S = 10;
  localparam int unsigned POS_T = 9;
  // Latencies in cycles
  localparam logic [1:0] LAT_BR_DLY = 2'h2;
  localparam logic [1:0] LAT_BR_NODLY = 2'h3;
  localparam logic [1:0] LAT_BRK = 2'h3;
  localparam logic [1:0] LAT_BS = 2'h2;
  localparam logic [XLEN-1:0] PC_RESET = 32'h0000_0000;
endpackage

// File: bse_shifter.sv
/*
  Barrel shifter: left or right, logical or arithmetic, by 0..31.
  Assumes operand and count are stable while the result is used.
*/
`timescale 1ns/1ps
module bse_shifter (
  // Operand and control
  input wire logic [bse_pkg::XLEN-1:0] src,
  input wire logic [bse_pkg::SHAMT_W-1:0] amount,
  input wire logic left,
  input wire logic arith,
  // Result
  output logic [bse_pkg::XLEN-1:0] result
);
  import bse_pkg::*;
  wire logic fill_bit;
  wire logic [XLEN-1:0] right_res;
  wire logic [XLEN-1:0] left_res;
  // Word bit 31 is bit 0 in big-endian numbering
  assign fill_bit = arith & src[XLEN-1];
  assign right_res = XLEN'($signed({fill_bit, src}) >>> amount);
  assign left_res = src << amount;
  assign result = left ? left_res : right_res;
endmodule

// File: testbench.sv
/*
  Self-checking bench for the branch, break and barrel-shift executor.
  Assumes the executor package and the design module are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import bse_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic issue_valid = 1'b0;
  logic [XLEN-1:0] instr = '0;
  logic [XLEN-1:0] first_source_register = '0;
  logic [XLEN-1:0] second_source_register = '0;
  logic break_clear = 1'b0;
  logic break_in_progress_flag, busy, illegal, pc_load, slot_allow, wr_en;
  logic [XLEN-1:0] pc, wr_data, wd, npc, opc;
  logic [RIDX_W-1:0] wr_idx, wi;
  logic [31:0] lp, lw, ls, li, bk;
  int fail_count = 0;
  int tests_run = 0;

  always #10 clk = ~clk;

  branch_shift_execute #(.USE_BARREL(1'b1)) i_branch_shift_execute (
    .clk(clk), .arst_n(arst_n), .issue_valid(issue_valid), .instr(instr),
    .first_source_register(first_source_register),
    .second_source_register(second_source_register), .break_clear(break_clear),
    .break_in_progress_flag(break_in_progress_flag), .busy(busy), .illegal(illegal),
    .pc(pc), .pc_load(pc_load), .slot_allow(slot_allow), .wr_en(wr_en),
    .wr_idx(wr_idx), .wr_data(wr_data)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Issue one word, then record in which cycle each pulse shows
  task automatic exec(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b);
    lp = 0;
    lw = 0;
    ls = 0;
    li = 0;
    bk = 0;
    opc = pc;
    @(posedge clk);
    issue_valid <= 1'b1;
    instr <= w;
    first_source_register <= a;
    second_source_register <= b;
    @(posedge clk);
    issue_valid <= 1'b0;
    for (int k = 1; k <= 6 && bk == 0; k++) begin
      #1;
      if (k == 1) npc = pc;
      if (pc_load === 1'b1) lp = k;
      if (slot_allow === 1'b1) ls = k;
      if (illegal === 1'b1) li = k;
      if (wr_en === 1'b1) begin
        lw = k;
        wd = wr_data;
        wi = wr_idx;
      end
      if (busy === 1'b0) begin
        bk = k;
      end else begin
        @(posedge clk);
      end
    end
    if (bk == 0) begin
      fail_count++;
      $display("wrong value busy expected 0 seen %b", busy);
      tally_and_finish();
    end
  endtask

  task automatic branch_case(input bit imm, input logic [2:0] dal, input logic [31:0] opnd);
    logic [31:0] lat;
    lat = dal[2] ? 32'h1 : 32'h2;
    exec({imm ? OPC_BR_IMM : OPC_BR_REG, 5'h07, dal, 2'b00, imm ? opnd[15:0] : 16'h1800},
         32'h0, imm ? ~opnd : opnd);
    check("next pc", dal[1] ? opnd : opc + opnd, npc);
    check("load cycle", lat, lp);
    check("busy end", lat + 32'h1, bk);
    check("slot cycle", dal[2] ? lat : 32'h0, ls);
    check("link cycle", dal[0] ? lat : 32'h0, lw);
    if (dal[0]) begin
      check("link data", opc, wd);
      check("link index", 32'h7, {27'h0, wi});
    end
  endtask

  task automatic t_branch_reg;
    logic [2:0] forms [6] = '{3'b000, 3'b010, 3'b100, 3'b110, 3'b101, 3'b111};
    foreach (forms[i]) branch_case(1'b0, forms[i], 32'h0000_0100 + 32'(i) * 32'h40);
  endtask

  task automatic t_branch_imm;
    logic [2:0] forms [6] = '{3'b000, 3'b010, 3'b100, 3'b110, 3'b101, 3'b111};
    foreach (forms[i]) begin
      branch_case(1'b1, forms[i], (i % 2) ? 32'h0000_0120 : 32'hFFFF_FFC0 - 32'(i));
    end
  endtask

  task automatic t_no_link_undelayed;
    for (int m = 0; m < 2; m++) begin
      exec({m ? OPC_BR_IMM : OPC_BR_REG, 5'h07, 5'h04, 16'h1800}, 32'h0, 32'h40);
      check("illegal pulse", 32'h1, li);
      check("no load", 32'h0, lp);
      check("no link", 32'h0, lw);
      check("pc kept", opc, npc);
    end
  endtask

  task automatic break_case(input logic [31:0] w, input logic [31:0] b, input logic [31:0] tgt);
    exec(w, 32'h0, b);
    check("break pc", tgt, npc);
    check("break link", opc, wd);
    check("break index", 32'h5, {27'h0, wi});
    check("break write cycle", 32'h2, lw);
    check("break busy end", 32'h3, bk);
    check("break flag", 32'h1, {31'h0, break_in_progress_flag});
    @(posedge clk);
    break_clear <= 1'b1;
    @(posedge clk);
    break_clear <= 1'b0;
    @(posedge clk);
    #1;
    check("break flag cleared", 32'h0, {31'h0, break_in_progress_flag});
  endtask

  task automatic t_break;
    break_case({OPC_BR_REG, 5'h05, BRK_SEL, 16'h1800}, 32'h0000_0200, 32'h0000_0200);
    exec({OPC_IMM_PFX, 10'h0, 16'h1234}, 32'h0, 32'h0);
    break_case({OPC_BR_IMM, 5'h05, BRK_SEL, 16'h5678}, 32'h0, 32'h1234_5678);
    break_case({OPC_BR_IMM, 5'h05, BRK_SEL, 16'hFFF0}, 32'h0, 32'hFFFF_FFF0);
  endtask

  task automatic shift_case(input bit imm, input bit s, input bit t, input logic [31:0] a,
                            input logic [31:0] b);
    logic [4:0] n;
    logic [31:0] exp;
    n = b[4:0];
    exp = s ? a << n : (t ? $unsigned($signed(a) >>> n) : a >> n);
    exec({imm ? OPC_BS_IMM : OPC_BS_REG, 5'h09, 5'h02,
          imm ? {5'h0, s, t, 4'h1, n} : {5'h3, s, t, 9'h0}}, a, imm ? ~b : b);
    check("shift result", exp, wd);
    check("shift write cycle", 32'h1, lw);
    check("shift busy end", 32'h2, bk);
    check("shift index", 32'h9, {27'h0, wi});
  endtask

  task automatic t_shift_reg;
    shift_case(1'b0, 1'b1, 1'b0, 32'h8000_00F1, 32'hFFFF_FFE4);
    shift_case(1'b0, 1'b0, 1'b0, 32'h8000_0001, 32'h0000_001F);
    shift_case(1'b0, 1'b0, 1'b1, 32'h8765_4321, 32'h0000_0007);
    shift_case(1'b0, 1'b0, 1'b1, 32'h8765_4321, 32'hFFFF_FFE0);
    shift_case(1'b0, 1'b0, 1'b1, 32'h7654_3210, 32'h0000_0011);
  endtask

  task automatic t_shift_imm;
    shift_case(1'b1, 1'b1, 1'b0, 32'h0F0F_1234, 32'h0000_001F);
    shift_case(1'b1, 1'b0, 1'b0, 32'hF000_000F, 32'h0000_0008);
    shift_case(1'b1, 1'b0, 1'b1, 32'h9000_0000, 32'h0000_0000);
    exec({OPC_IMM_PFX, 10'h0, 16'hFFFF}, 32'h0, 32'h0);
    shift_case(1'b1, 1'b0, 1'b1, 32'h8000_0000, 32'h0000_0003);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("reset pc", PC_RESET, pc);
    check("reset busy", 32'h0, {31'h0, busy});
    t_branch_reg();
    t_branch_imm();
    t_no_link_undelayed();
    t_break();
    t_shift_reg();
    t_shift_imm();
    tally_and_finish();
  end
endmodule
